// ===== src/pfs_pkg.sv
// Constants for the port A pin function select block.
// Assumes a 16-bit register port and sixteen multiplexed pins.
package pfs_pkg;
   localparam int          PFS_DATA_W         = 16;
   localparam int          PFS_ADDR_W         = 4;
   localparam int          PFS_PINS           = 16;
   localparam int          PFS_FIRST_UPPER    = 8;
   localparam logic [3:0]  PFS_UPPER_OFFSET   = 4'h8;
   localparam logic [3:0]  PFS_LOWER_OFFSET   = 4'hA;
   localparam logic [15:0] PFS_UPPER_RESET    = 16'h3302;
   localparam logic [15:0] PFS_LOWER_RESET    = 16'hFF95;
   localparam logic [15:0] PFS_UPPER_FIXED    = 16'h0002;
   localparam logic [15:0] PFS_LOWER_FIXED    = 16'hAA00;
   localparam logic [15:0] PFS_TWO_BIT_PINS   = 16'hFE0F;
   // Low bit of each pin's select field, pin 15 in the top nibble.
   localparam logic [15:0][3:0] PFS_FIELD_LSB      = 64'hECA8_6420_ECA8_6420;
   // Reserved select codes of each pin, bit n set when code n is reserved.
   localparam logic [15:0][3:0] PFS_RESERVED_CODES = 64'h4400_884C_CCCC_8888;
   localparam int          PFS_CODE_PORT      = 0;
   localparam int          PFS_CODE_F1        = 1;
   localparam int          PFS_CODE_F2        = 2;
   localparam int          PFS_CODE_F3        = 3;
endpackage : pfs_pkg

// ===== src/pfs_pin_decode.sv
// Decodes one pin's select code into a one-hot function choice.
// Assumes the code is already aligned; reserved codes fall back to port I/O.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_decode #(
   parameter logic [3:0] RESERVED = 4'h0
) (
   input  wire logic [1:0] sel,
   output wire logic [3:0] onehot
);
   // A reserved code selects plain port I/O so the pin never drives an undefined function.
   assign onehot = RESERVED[sel] ? 4'b0001 : (4'b0001 << sel);
endmodule : pfs_pin_decode
`default_nettype wire

// ===== src/pfs_port_a_top.sv
// Port A pin function select registers and their per-pin function decode.
// Assumes srst is the power-on reset and strobes come from one bus master on clk.
//
// What this block does
// - Two 16-bit read/write selects: upper covers pins 15-8, lower pins 7-0.
// - Power-on reset loads 0x3302 and 0xFF95; other resets and sleep keep contents.
// - Pin 15: 00 port, 01 interrupt in 3, 11 DMA request 1, 10 reserved.
// - Pin 14: 00 port, 01 interrupt in 2, 11 DMA acknowledge 1, 10 reserved.
// - Pin 13: 00 port, 01 interrupt in 1, 10 timer clock B, 11 DMA request 0.
// - Pin 12: 00 port, 01 interrupt in 0, 10 timer clock A, 11 DMA acknowledge 0.
// - Pin 11: 00 port, 01 upper bus parity, 10 capture/compare B1, 11 reserved.
// - Pin 10: 00 port, 01 lower bus parity, 10 capture/compare A1, 11 reserved.
// - Pin 9: 00 port, 01 address hold, 11 interrupt request out, 10 reserved.
// - Upper bit 1 is reserved, reads 1; software writes 1.
// - Upper bit 0: 0 port, 1 bus request input; resets to 0.
// - Lower bits 15, 13, 11, 9 reserved, read 1; software writes 1.
// - Lower holds one-bit selects for pins 7-4, two-bit fields for pins 3-0.
// - Pin 7: 0 port, 1 bus grant acknowledge output; resets to 1.
// - Pins 6, 5, 4: 1 selects read, upper write, lower write strobes.
// - Pin 3: 00 port, 01 select out 7, 10 wait input, 11 reserved.
// - Pins 2-0: 01 select outs 6-4; 10 capcmp B0, row strobe, capcmp A0.
`timescale 1ns/1ps
`default_nettype none
module pfs_port_a_top (
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire logic [pfs_pkg::PFS_ADDR_W-1:0] bus_addr,
   input  wire logic [pfs_pkg::PFS_DATA_W-1:0] bus_wdata,
   input  wire logic                      bus_wr,
   input  wire logic                      bus_rd,
   output logic      [pfs_pkg::PFS_DATA_W-1:0] bus_rdata,
   output logic      [pfs_pkg::PFS_PINS-1:0]   port_io_en,
   output logic      [3:0]                ext_interrupt_in_en,
   output logic      [1:0]                dma_req_in_en,
   output logic      [1:0]                dma_ack_out_en,
   output logic                           timer_ext_clock_a_en,
   output logic                           timer_ext_clock_b_en,
   output logic                           upper_bus_parity_en,
   output logic                           lower_bus_parity_en,
   output logic                           timer_capcmp_a1_en,
   output logic                           timer_capcmp_b1_en,
   output logic                           timer_capcmp_a0_en,
   output logic                           timer_capcmp_b0_en,
   output logic                           address_latch_hold_out_en,
   output logic                           interrupt_request_out_en,
   output logic                           bus_request_in_en,
   output logic                           bus_grant_ack_out_en,
   output logic                           read_strobe_out_en,
   output logic                           high_byte_store_strobe_en,
   output logic                           low_byte_store_strobe_en,
   output logic      [3:0]                select_out_en,
   output logic                           wait_state_in_en,
   output logic                           row_addr_strobe_out_en
);
   import pfs_pkg::*;

   typedef struct packed {
      logic [15:0] upper_reg;
      logic [15:0] lower_reg;
      logic [15:0] rdata_reg;
      logic [15:0] port_io_reg;
      logic [3:0]  ext_irq_reg;
      logic [1:0]  dma_req_reg;
      logic [1:0]  dma_ack_reg;
      logic        tclk_a_reg;
      logic        tclk_b_reg;
      logic        par_hi_reg;
      logic        par_lo_reg;
      logic        cc_a1_reg;
      logic        cc_b1_reg;
      logic        cc_a0_reg;
      logic        cc_b0_reg;
      logic        ah_reg;
      logic        irq_out_reg;
      logic        bus_request_in_reg;
      logic        back_reg;
      logic        rd_stb_reg;
      logic        hi_stb_reg;
      logic        lo_stb_reg;
      logic [3:0]  sel_out_reg;
      logic        wait_reg;
      logic        ras_reg;
   } pfs_state_t;

   pfs_state_t  st_reg;
   pfs_state_t  st_next;
   logic [15:0] upper_next;
   logic [15:0] lower_next;
   logic [1:0]  field_w  [PFS_PINS];
   logic [3:0]  dec_w    [PFS_PINS];

   // Next value of one select register; reserved bits are always stored as ones.
   function automatic logic [15:0] sel_next(
      input logic [15:0] cur,
      input logic [15:0] rst_val,
      input logic [15:0] fixed,
      input logic        rst,
      input logic        hit,
      input logic [15:0] wdata
   );
      logic [15:0] v;
      v = cur;
      if (rst) begin
         v = rst_val;
      end else if (hit) begin
         v = wdata | fixed;
      end
      return v;
   endfunction : sel_next

   // Extracts a pin's select field; single-bit selects get a zero high bit.
   function automatic logic [1:0] pin_field(
      input int          pin,
      input logic [15:0] up,
      input logic [15:0] lo
   );
      logic [15:0] src;
      logic [3:0]  lsb;
      logic [1:0]  f;
      src = (pin >= PFS_FIRST_UPPER) ? up : lo;
      lsb = PFS_FIELD_LSB[pin];
      f   = src[lsb +: 2];
      if (!PFS_TWO_BIT_PINS[pin]) begin
         f[1] = 1'b0;
      end
      return f;
   endfunction : pin_field

   // Only the power-on reset and a write at the register's offset change the selects; otherwise they hold.
   assign upper_next = sel_next(st_reg.upper_reg, PFS_UPPER_RESET, PFS_UPPER_FIXED, srst,
                                bus_wr && (bus_addr == PFS_UPPER_OFFSET), bus_wdata);
   assign lower_next = sel_next(st_reg.lower_reg, PFS_LOWER_RESET, PFS_LOWER_FIXED, srst,
                                bus_wr && (bus_addr == PFS_LOWER_OFFSET), bus_wdata);

   genvar g;
   generate
      for (g = 0; g < PFS_PINS; g++) begin : g_pin
         assign field_w[g] = pin_field(g, upper_next, lower_next);
         pfs_pin_decode #(
            .RESERVED (PFS_RESERVED_CODES[g])
         ) u_dec (
            .sel    (field_w[g]),
            .onehot (dec_w[g])
         );
      end
   endgenerate

   always_comb begin
      st_next           = st_reg;
      st_next.upper_reg = upper_next;
      st_next.lower_reg = lower_next;
      st_next.rdata_reg = '0;
      if (!srst && bus_rd) begin
         if (bus_addr == PFS_UPPER_OFFSET) begin
            st_next.rdata_reg = st_reg.upper_reg | PFS_UPPER_FIXED;
         end else if (bus_addr == PFS_LOWER_OFFSET) begin
            st_next.rdata_reg = st_reg.lower_reg | PFS_LOWER_FIXED;
         end
      end
      for (int p = 0; p < PFS_PINS; p++) begin
         st_next.port_io_reg[p] = dec_w[p][PFS_CODE_PORT];
      end
      st_next.ext_irq_reg = {dec_w[15][PFS_CODE_F1], dec_w[14][PFS_CODE_F1],
                             dec_w[13][PFS_CODE_F1], dec_w[12][PFS_CODE_F1]};
      st_next.dma_req_reg = {dec_w[15][PFS_CODE_F3], dec_w[13][PFS_CODE_F3]};
      st_next.dma_ack_reg = {dec_w[14][PFS_CODE_F3], dec_w[12][PFS_CODE_F3]};
      st_next.tclk_b_reg  = dec_w[13][PFS_CODE_F2];
      st_next.tclk_a_reg  = dec_w[12][PFS_CODE_F2];
      st_next.par_hi_reg  = dec_w[11][PFS_CODE_F1];
      st_next.cc_b1_reg   = dec_w[11][PFS_CODE_F2];
      st_next.par_lo_reg  = dec_w[10][PFS_CODE_F1];
      st_next.cc_a1_reg   = dec_w[10][PFS_CODE_F2];
      st_next.ah_reg      = dec_w[9][PFS_CODE_F1];
      st_next.irq_out_reg = dec_w[9][PFS_CODE_F3];
      st_next.bus_request_in_reg    = dec_w[8][PFS_CODE_F1];
      st_next.back_reg    = dec_w[7][PFS_CODE_F1];
      st_next.rd_stb_reg  = dec_w[6][PFS_CODE_F1];
      st_next.hi_stb_reg  = dec_w[5][PFS_CODE_F1];
      st_next.lo_stb_reg  = dec_w[4][PFS_CODE_F1];
      st_next.sel_out_reg = {dec_w[3][PFS_CODE_F1], dec_w[2][PFS_CODE_F1],
                             dec_w[1][PFS_CODE_F1], dec_w[0][PFS_CODE_F1]};
      st_next.wait_reg    = dec_w[3][PFS_CODE_F2];
      st_next.cc_b0_reg   = dec_w[2][PFS_CODE_F2];
      st_next.ras_reg     = dec_w[1][PFS_CODE_F2];
      st_next.cc_a0_reg   = dec_w[0][PFS_CODE_F2];
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   assign bus_rdata                 = st_reg.rdata_reg;
   assign port_io_en                = st_reg.port_io_reg;
   assign ext_interrupt_in_en       = st_reg.ext_irq_reg;
   assign dma_req_in_en             = st_reg.dma_req_reg;
   assign dma_ack_out_en            = st_reg.dma_ack_reg;
   assign timer_ext_clock_a_en      = st_reg.tclk_a_reg;
   assign timer_ext_clock_b_en      = st_reg.tclk_b_reg;
   assign upper_bus_parity_en       = st_reg.par_hi_reg;
   assign lower_bus_parity_en       = st_reg.par_lo_reg;
   assign timer_capcmp_a1_en        = st_reg.cc_a1_reg;
   assign timer_capcmp_b1_en        = st_reg.cc_b1_reg;
   assign timer_capcmp_a0_en        = st_reg.cc_a0_reg;
   assign timer_capcmp_b0_en        = st_reg.cc_b0_reg;
   assign address_latch_hold_out_en = st_reg.ah_reg;
   assign interrupt_request_out_en  = st_reg.irq_out_reg;
   assign bus_request_in_en         = st_reg.bus_request_in_reg;
   assign bus_grant_ack_out_en      = st_reg.back_reg;
   assign read_strobe_out_en        = st_reg.rd_stb_reg;
   assign high_byte_store_strobe_en = st_reg.hi_stb_reg;
   assign low_byte_store_strobe_en  = st_reg.lo_stb_reg;
   assign select_out_en             = st_reg.sel_out_reg;
   assign wait_state_in_en          = st_reg.wait_reg;
   assign row_addr_strobe_out_en    = st_reg.ras_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_reset_values: assert property ($fell(srst) |->
      (st_reg.upper_reg == PFS_UPPER_RESET) && (st_reg.lower_reg == PFS_LOWER_RESET)
      && bus_grant_ack_out_en && !bus_request_in_en && dma_ack_out_en == 2'b11)
      else $error("select registers not at power-on values after reset");

   chk_upper_write: assert property (!srst && bus_wr && bus_addr == PFS_UPPER_OFFSET
      |=> st_reg.upper_reg == ($past(bus_wdata) | PFS_UPPER_FIXED))
      else $error("upper select write not stored");

   chk_lower_write: assert property (!srst && bus_wr && bus_addr == PFS_LOWER_OFFSET
      |=> st_reg.lower_reg == ($past(bus_wdata) | PFS_LOWER_FIXED))
      else $error("lower select write not stored");

   chk_regs_hold: assert property (!bus_wr |=>
      $stable(st_reg.upper_reg) && $stable(st_reg.lower_reg))
      else $error("select register changed without a write");

   chk_upper_readback: assert property (bus_rd && bus_addr == PFS_UPPER_OFFSET |=>
      bus_rdata == $past(st_reg.upper_reg) && bus_rdata[1])
      else $error("upper readback wrong or reserved bit low");

   chk_lower_readback: assert property (bus_rd && bus_addr == PFS_LOWER_OFFSET |=>
      bus_rdata == $past(st_reg.lower_reg)
      && (bus_rdata & PFS_LOWER_FIXED) == PFS_LOWER_FIXED)
      else $error("lower readback wrong or reserved bits low");

   chk_unmapped_read: assert property (bus_rd && bus_addr != PFS_UPPER_OFFSET
      && bus_addr != PFS_LOWER_OFFSET |=> bus_rdata == 16'h0000)
      else $error("unmapped read returned nonzero data");

   chk_write_to_enable: assert property (!srst && bus_wr && bus_addr == PFS_UPPER_OFFSET
      && bus_wdata[15:14] == 2'b11 |=> dma_req_in_en[1] && !ext_interrupt_in_en[3]
      && !port_io_en[15])
      else $error("pin 15 DMA request not enabled one cycle after write");

   chk_pin14_map: assert property (
      dma_ack_out_en[1] == (st_reg.upper_reg[13:12] == 2'b11)
      && ext_interrupt_in_en[2] == (st_reg.upper_reg[13:12] == 2'b01))
      else $error("pin 14 function decode wrong");

   chk_pin13_map: assert property (
      timer_ext_clock_b_en == (st_reg.upper_reg[11:10] == 2'b10)
      && dma_req_in_en[0] == (st_reg.upper_reg[11:10] == 2'b11)
      && ext_interrupt_in_en[1] == (st_reg.upper_reg[11:10] == 2'b01))
      else $error("pin 13 function decode wrong");

   chk_pin12_map: assert property (
      timer_ext_clock_a_en == (st_reg.upper_reg[9:8] == 2'b10)
      && dma_ack_out_en[0] == (st_reg.upper_reg[9:8] == 2'b11)
      && ext_interrupt_in_en[0] == (st_reg.upper_reg[9:8] == 2'b01))
      else $error("pin 12 function decode wrong");

   chk_pin11_map: assert property (
      upper_bus_parity_en == (st_reg.upper_reg[7:6] == 2'b01)
      && timer_capcmp_b1_en == (st_reg.upper_reg[7:6] == 2'b10))
      else $error("pin 11 function decode wrong");

   chk_pin10_map: assert property (
      lower_bus_parity_en == (st_reg.upper_reg[5:4] == 2'b01)
      && timer_capcmp_a1_en == (st_reg.upper_reg[5:4] == 2'b10))
      else $error("pin 10 function decode wrong");

   chk_pin9_map: assert property (
      address_latch_hold_out_en == (st_reg.upper_reg[3:2] == 2'b01)
      && interrupt_request_out_en == (st_reg.upper_reg[3:2] == 2'b11))
      else $error("pin 9 function decode wrong");

   chk_pin8_map: assert property (bus_request_in_en == st_reg.upper_reg[0]
      && port_io_en[8] == !st_reg.upper_reg[0])
      else $error("pin 8 function decode wrong");

   chk_pin7_map: assert property (bus_grant_ack_out_en == st_reg.lower_reg[14])
      else $error("pin 7 function decode wrong");

   chk_strobe_map: assert property (read_strobe_out_en == st_reg.lower_reg[12]
      && high_byte_store_strobe_en == st_reg.lower_reg[10]
      && low_byte_store_strobe_en == st_reg.lower_reg[8])
      else $error("pin 6 to 4 strobe decode wrong");

   chk_pin3_map: assert property (select_out_en[3] == (st_reg.lower_reg[7:6] == 2'b01)
      && wait_state_in_en == (st_reg.lower_reg[7:6] == 2'b10))
      else $error("pin 3 function decode wrong");

   chk_pin2_0_map: assert property (
      timer_capcmp_b0_en == (st_reg.lower_reg[5:4] == 2'b10)
      && row_addr_strobe_out_en == (st_reg.lower_reg[3:2] == 2'b10)
      && timer_capcmp_a0_en == (st_reg.lower_reg[1:0] == 2'b10)
      && select_out_en[2:0] == {st_reg.lower_reg[5:4] == 2'b01,
      st_reg.lower_reg[3:2] == 2'b01, st_reg.lower_reg[1:0] == 2'b01})
      else $error("pins 2 to 0 function decode wrong");

   chk_reserved_port: assert property ((st_reg.upper_reg[15:14] == 2'b10
      |-> port_io_en[15]) and (st_reg.lower_reg[7:6] == 2'b11 |-> port_io_en[3]))
      else $error("reserved code did not fall back to port I/O");

   cov_write_read_upper: cover property (bus_wr && bus_addr == PFS_UPPER_OFFSET
      ##1 bus_rd && bus_addr == PFS_UPPER_OFFSET);
   cov_reserved_code: cover property (bus_wr && bus_addr == PFS_LOWER_OFFSET
      && bus_wdata[1:0] == 2'b11);
   cov_timer_clock_b: cover property (timer_ext_clock_b_en);
   cov_all_port_io: cover property (port_io_en == 16'hFFFF);

endmodule : pfs_port_a_top
`default_nettype wire

// ===== tb/pfs_port_a_top_tb.sv
// Self-checking bench for the port A pin function select block.
// Assumes the block's register port, one 20 MHz clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_errors++; \
   $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module pfs_port_a_top_tb;
   import pfs_pkg::*;
   localparam logic [3:0] UP = PFS_UPPER_OFFSET;
   localparam logic [3:0] LO = PFS_LOWER_OFFSET;
   logic        clk       = 1'b0;
   logic        srst      = 1'b1;
   logic [3:0]  bus_addr  = 4'h0;
   logic [15:0] bus_wdata = 16'h0000;
   logic        bus_wr    = 1'b0;
   logic        bus_rd    = 1'b0;
   logic [15:0] bus_rdata;
   logic [15:0] port_io_en;
   logic [3:0]  irq_en;
   logic [1:0]  dreq_en;
   logic [1:0]  dack_en;
   logic [3:0]  sel_en;
   wire  [17:0] misc_en;
   logic [45:0] seen;
   logic [15:0] mu;
   logic [15:0] ml;
   int          n_errors     = 0;
   int          total_checks = 0;

   always #25 clk = ~clk;

   pfs_port_a_top dut (
      .clk                       (clk),
      .srst                      (srst),
      .bus_addr                  (bus_addr),
      .bus_wdata                 (bus_wdata),
      .bus_wr                    (bus_wr),
      .bus_rd                    (bus_rd),
      .bus_rdata                 (bus_rdata),
      .port_io_en                (port_io_en),
      .ext_interrupt_in_en       (irq_en),
      .dma_req_in_en             (dreq_en),
      .dma_ack_out_en            (dack_en),
      .timer_ext_clock_a_en      (misc_en[17]),
      .timer_ext_clock_b_en      (misc_en[16]),
      .upper_bus_parity_en       (misc_en[15]),
      .lower_bus_parity_en       (misc_en[14]),
      .timer_capcmp_a1_en        (misc_en[13]),
      .timer_capcmp_b1_en        (misc_en[12]),
      .timer_capcmp_a0_en        (misc_en[11]),
      .timer_capcmp_b0_en        (misc_en[10]),
      .address_latch_hold_out_en (misc_en[9]),
      .interrupt_request_out_en  (misc_en[8]),
      .bus_request_in_en         (misc_en[7]),
      .bus_grant_ack_out_en      (misc_en[6]),
      .read_strobe_out_en        (misc_en[5]),
      .high_byte_store_strobe_en (misc_en[4]),
      .low_byte_store_strobe_en  (misc_en[3]),
      .select_out_en             (sel_en),
      .wait_state_in_en          (misc_en[2]),
      .row_addr_strobe_out_en    (misc_en[1])
   );
   assign misc_en[0] = 1'b0;
   assign seen = {port_io_en, irq_en, dreq_en, dack_en, sel_en, misc_en};

   // Expected enables of every pin function for given register contents.
   function automatic logic [45:0] model_en(input logic [15:0] u, input logic [15:0] l);
      logic [1:0]  c15, c14, c13, c12, c11, c10, c9, c3, c2, c1, c0;
      logic [15:0] pio;
      {c15, c14, c13, c12, c11, c10, c9} = u[15:2];
      {c3, c2, c1, c0} = l[7:0];
      pio = {c15 == 0 || c15 == 2, c14 == 0 || c14 == 2, c13 == 0, c12 == 0,
             c11 == 0 || c11 == 3, c10 == 0 || c10 == 3, c9 == 0 || c9 == 2, !u[0],
             !l[14], !l[12], !l[10], !l[8], c3 == 0 || c3 == 3, c2 == 0 || c2 == 3,
             c1 == 0 || c1 == 3, c0 == 0 || c0 == 3};
      return {pio, c15 == 1, c14 == 1, c13 == 1, c12 == 1, c15 == 3, c13 == 3,
              c14 == 3, c12 == 3, c3 == 1, c2 == 1, c1 == 1, c0 == 1,
              c12 == 2, c13 == 2, c11 == 1, c10 == 1, c10 == 2, c11 == 2, c0 == 2,
              c2 == 2, c9 == 1, c9 == 3, u[0], l[14], l[12], l[10], l[8], c3 == 2,
              c1 == 2, 1'b0};
   endfunction : model_en

   task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
      if (a == UP) mu = d | 16'h0002;
      else if (a == LO) ml = d | 16'haa00;
      bus_addr  <= a;
      bus_wdata <= d;
      bus_rd    <= 1'b0;
      bus_wr    <= 1'b1;
      @(posedge clk);
   endtask : bus_write

   task automatic bus_read(input logic [3:0] a);
      logic [15:0] ex;
      ex = (a == UP) ? mu : ((a == LO) ? ml : 16'h0000);
      bus_addr <= a;
      bus_wr   <= 1'b0;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      `CHK("read data", ex, bus_rdata)
      @(posedge clk);
      @(negedge clk);
      `CHK("idle read data", 16'h0000, bus_rdata)
      @(posedge clk);
   endtask : bus_read

   task automatic check_en();
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      @(negedge clk);
      `CHK("enables", model_en(mu, ml), seen)
      @(posedge clk);
   endtask : check_en

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      end_of_test();
   end

   initial begin
      logic [1:0]  cd;
      logic [3:0]  ad;
      logic [15:0] wd;
      void'($urandom(98741));
      mu = 16'h3302;
      ml = 16'hff95;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      check_en();
      bus_read(UP);
      bus_read(LO);
      $display("test reset values done");
      for (int c = 0; c < 4; c++) begin
         cd = 2'(c);
         bus_write(UP, {{7{cd}}, 1'b1, cd[0]});
         bus_write(LO, {{4{1'b1, cd[0]}}, {4{cd}}});
         check_en();
         bus_read(UP);
         bus_read(LO);
      end
      $display("test every select code done");
      for (int a = 0; a < 16; a++) begin
         ad = 4'(a);
         if (ad != UP && ad != LO) begin
            bus_write(ad, 16'($urandom));
            bus_read(ad);
         end
      end
      check_en();
      bus_read(UP);
      bus_read(LO);
      $display("test unmapped addresses done");
      for (int i = 0; i < 150; i++) begin
         ad = ($urandom % 2 == 0) ? UP : LO;
         wd = 16'($urandom) | ((ad == UP) ? PFS_UPPER_FIXED : PFS_LOWER_FIXED);
         bus_write(ad, wd);
         bus_read(ad);
         check_en();
      end
      $display("test random traffic done");
      bus_write(UP, 16'h0000);
      bus_write(LO, 16'h0000);
      check_en();
      srst      <= 1'b1;
      bus_addr  <= LO;
      bus_wdata <= 16'h5555;
      bus_wr    <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      mu = 16'h3302;
      ml = 16'hff95;
      check_en();
      bus_read(UP);
      bus_read(LO);
      $display("test reset in mid run done");
      end_of_test();
   end
endmodule : pfs_port_a_top_tb
`default_nettype wire
